// *** hdl/ext_irq_top.sv ***
// Module: external interrupt inputs with AHB-Lite register slave
// Operation
// - Four inputs, each gated by pin select
// - Any input may optionally wake processor
// - Flag register holds one flag per input
// - Wake enable bits let inputs wake processor
// - Sensitivity register picks level or edge
// - Polarity register picks active level or edge
// - Active condition sets flag, raises request
// - Write one clears; level mode needs inactive
// - Sensitivity zero level, one edge
// - Wake ignores interrupt controller enable
`timescale 1ns/1ps
module ext_irq_top #(
  parameter int N = ext_irq_pkg::NUM_INPUTS
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [N-1:0] irq_pin,
  input  wire logic [N-1:0] pin_select,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic      [1:0]  hresp,
  output logic      [N-1:0] irq_request,
  output logic             wake_request,
  output logic             irq
);
  typedef struct packed {
    logic [N-1:0] flags;
    logic [N-1:0] wake_en;
    logic [N-1:0] sense;
    logic [N-1:0] polar;
    logic [N-1:0] mask;
    logic         wr_pend;
    logic [31:0]  wr_addr;
    logic [31:0]  rdata;
    logic [N-1:0] req;
    logic         wake;
    logic         irq;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;
  logic       access;
  logic [N-1:0] clr;
  logic [N-1:0] wr_bits;

  ext_irq_cfg_if #(.N(N)) cfg ();

  // ==========================================================================
  // Detector
  // ==========================================================================
  assign cfg.pin_level   = irq_pin;
  assign cfg.pin_select  = pin_select;
  assign cfg.sensitivity = s_q.sense;
  assign cfg.polarity    = s_q.polar;

  ext_irq_detect #(.N(N)) u_detect (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .cfg     (cfg)
  );

  // ==========================================================================
  // Bus decode helpers
  // ==========================================================================
  // Only NONSEQ or SEQ with hready qualify as a real address phase
  assign access  = hsel & hready &
                   ((htrans == ext_irq_pkg::HTRANS_NONSEQ) |
                    (htrans == ext_irq_pkg::HTRANS_SEQ));
  assign wr_bits = hwdata[N-1:0];

  // Clear blocked in level mode while pin stays active
  always_comb begin
    clr = '0;
    if (s_q.wr_pend && s_q.wr_addr == ext_irq_pkg::ADDR_FLAGS) begin
      clr = wr_bits & ~(~s_q.sense & cfg.active_level);
    end
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    s_d         = s_q;
    s_d.wr_pend = 1'h0;
    // Data phase of a write: registers update here
    if (s_q.wr_pend) begin
      if (s_q.wr_addr == ext_irq_pkg::ADDR_WAKE_ENABLE) begin
        s_d.wake_en = wr_bits;
      end else if (s_q.wr_addr == ext_irq_pkg::ADDR_SENSITIVITY) begin
        s_d.sense = wr_bits;
      end else if (s_q.wr_addr == ext_irq_pkg::ADDR_POLARITY) begin
        s_d.polar = wr_bits;
      end else if (s_q.wr_addr == ext_irq_pkg::ADDR_IRQ_MASK) begin
        s_d.mask = wr_bits;
      end
    end
    // Set wins over a clear in the same cycle
    s_d.flags = (s_q.flags & ~clr) | cfg.set_event;
    // Address phase capture and read data prepared for the data phase
    if (access) begin
      s_d.wr_pend = hwrite;
      s_d.wr_addr = haddr;
      s_d.rdata   = ext_irq_pkg::READ_ZERO;
      if (!hwrite) begin
        if (haddr == ext_irq_pkg::ADDR_FLAGS) begin
          s_d.rdata[N-1:0] = s_d.flags;
        end else if (haddr == ext_irq_pkg::ADDR_WAKE_ENABLE) begin
          s_d.rdata[N-1:0] = s_q.wake_en;
        end else if (haddr == ext_irq_pkg::ADDR_SENSITIVITY) begin
          s_d.rdata[N-1:0] = s_q.sense;
        end else if (haddr == ext_irq_pkg::ADDR_POLARITY) begin
          s_d.rdata[N-1:0] = s_q.polar;
        end else if (haddr == ext_irq_pkg::ADDR_IRQ_MASK) begin
          s_d.rdata[N-1:0] = s_q.mask;
        end else begin
          s_d.rdata = ext_irq_pkg::READ_ZERO;
        end
      end
    end
    // Requests follow the flags; controller enable is outside this block
    s_d.req  = s_d.flags;
    // Wake uses the flag, so it works even with the request disabled
    s_d.wake = |(s_d.flags & s_d.wake_en);
    s_d.irq  = |(s_d.flags & s_d.mask);
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_q         <= '0;
      s_q.wake_en <= N'(ext_irq_pkg::CTRL_RESET);
      s_q.sense   <= N'(ext_irq_pkg::CTRL_RESET);
      s_q.polar   <= N'(ext_irq_pkg::CTRL_RESET);
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs from flip-flops, hreadyout and hresp tied constant; slave is zero wait state
  // ==========================================================================
  assign hrdata       = s_q.rdata;
  assign hreadyout    = 1'h1;
  assign hresp        = ext_irq_pkg::HRESP_OKAY;
  assign irq_request  = s_q.req;
  assign wake_request = s_q.wake;
  assign irq          = s_q.irq;
endmodule

// *** hdl/ext_irq_pkg.sv ***
// Package: register map, field layout and reset values of the external interrupt block
package ext_irq_pkg;
  // ==========================================================================
  // Geometry
  // ==========================================================================
  localparam int NUM_INPUTS = 4;
  localparam int REG_WIDTH  = 8;

  // ==========================================================================
  // Register byte addresses (word aligned)
  // ==========================================================================
  localparam logic [31:0] ADDR_FLAGS       = 32'he01fc140;
  localparam logic [31:0] ADDR_WAKE_ENABLE = 32'he01fc144;
  localparam logic [31:0] ADDR_SENSITIVITY = 32'he01fc148;
  localparam logic [31:0] ADDR_POLARITY    = 32'he01fc14c;
  localparam logic [31:0] ADDR_IRQ_MASK    = 32'he01fc150;

  // ==========================================================================
  // Reset values and encodings
  // ==========================================================================
  localparam logic [3:0]  CTRL_RESET   = 4'h0;
  localparam logic [31:0] READ_ZERO    = 32'h00000000;
  localparam logic        SENSE_LEVEL  = 1'h0;
  localparam logic        SENSE_EDGE   = 1'h1;
  localparam logic        POLAR_LOW    = 1'h0;
  localparam logic        POLAR_HIGH   = 1'h1;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
  localparam logic [1:0]  HRESP_OKAY    = 2'h0;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
endpackage

// *** hdl/ext_irq_cfg_if.sv ***
// Interface: per-input configuration and detection results between top and detector
`timescale 1ns/1ps
interface ext_irq_cfg_if #(
  parameter int N = 4
);
  logic [N-1:0] pin_level;
  logic [N-1:0] pin_select;
  logic [N-1:0] sensitivity;
  logic [N-1:0] polarity;
  logic [N-1:0] set_event;
  logic [N-1:0] active_level;

  modport ctrl (
    output pin_level,
    output pin_select,
    output sensitivity,
    output polarity,
    input  set_event,
    input  active_level
  );
  modport det (
    input  pin_level,
    input  pin_select,
    input  sensitivity,
    input  polarity,
    output set_event,
    output active_level
  );
endinterface

// *** hdl/ext_irq_detect.sv ***
// Module: per-input level and edge detector for the external interrupt pins
`timescale 1ns/1ps
module ext_irq_detect #(
  parameter int N = 4
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  ext_irq_cfg_if.det cfg
);
  typedef struct packed {
    logic [N-1:0] prev;
    logic [N-1:0] seen;
  } det_state_t;

  det_state_t s_q;
  det_state_t s_d;
  logic [N-1:0] act;
  logic [N-1:0] evt;

  // ==========================================================================
  // Per-input detection
  // ==========================================================================
  for (genvar i = 0; i < N; i++) begin : g_in
    // Active level follows polarity: one means high
    assign act[i] = (cfg.polarity[i] == ext_irq_pkg::POLAR_HIGH) ?
                    cfg.pin_level[i] : ~cfg.pin_level[i];
    // Edge mode needs a valid previous sample, level mode just the level
    assign evt[i] = cfg.pin_select[i] &
                    ((cfg.sensitivity[i] == ext_irq_pkg::SENSE_EDGE) ?
                     (act[i] & ~s_q.prev[i] & s_q.seen[i]) : act[i]);
  end

  assign cfg.set_event    = evt;
  assign cfg.active_level = act & cfg.pin_select;

  // Previous active sample; seen blocks a false edge right after reset
  always_comb begin
    s_d      = s_q;
    s_d.prev = act;
    s_d.seen = {N{1'h1}};
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// *** sim/ext_irq_props.sv ***
// Checker: port-level properties of the external interrupt block
`timescale 1ns/1ps
module ext_irq_props #(
  parameter int N = 4
) (
  input wire logic         ref_clk,
  input wire logic         sys_rst,
  input wire logic [N-1:0] pin_select,
  input wire logic         hsel,
  input wire logic [31:0]  haddr,
  input wire logic [1:0]   htrans,
  input wire logic         hwrite,
  input wire logic         hready,
  input wire logic [31:0]  hrdata,
  input wire logic         hreadyout,
  input wire logic [1:0]   hresp,
  input wire logic [N-1:0] irq_request,
  input wire logic         wake_request,
  input wire logic         irq
);
  // ========
  // Data-phase trackers
  logic rd_q;
  logic wr_q;
  logic bad_q;
  wire  take = hsel && hready && htrans[1];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Remember what sits in the data phase; unmapped means outside 0x140..0x150
  always_ff @(posedge ref_clk) begin
    rd_q  <= !sys_rst && take && !hwrite;
    wr_q  <= !sys_rst && take && hwrite && haddr == ext_irq_pkg::ADDR_FLAGS;
    bad_q <= !sys_rst && take && !hwrite
             && (haddr[31:5] != 27'h700fe0a || (haddr[4] && haddr[3:2] != 2'h0));
  end
  // ========
  // Properties
  a_bus_okay: assert property (hreadyout && hresp == ext_irq_pkg::HRESP_OKAY)
    else $error("bus slave not ready or not okay");
  a_reset_quiet: assert property ($fell(sys_rst) |-> irq_request == '0 && !wake_request && !irq)
    else $error("outputs not cleared by reset");
  a_req_select: assert property ((irq_request & ~$past(irq_request)
    & ~($past(pin_select) | $past(pin_select, 2) | $past(pin_select, 3))) == '0)
    else $error("request rose on an unselected input");
  // A flag only drops after a write to the flag register
  a_flag_sticky: assert property (($past(irq_request) & ~irq_request) != '0
    |-> $past(wr_q) || $past(wr_q, 2) || $past(wr_q, 3)) else $error("flag dropped unasked");
  a_upper_zero: assert property (rd_q |-> hrdata[31:N] == '0)
    else $error("reserved read bits not zero");
  a_unmapped_zero: assert property (bad_q |-> hrdata == '0)
    else $error("unmapped read not zero");
  a_irq_flag: assert property (irq |-> irq_request != '0)
    else $error("interrupt without a flag");
  a_wake_flag: assert property (wake_request |-> irq_request != '0)
    else $error("wake without a flag");
  c_irq: cover property ($rose(irq));
  c_wake: cover property ($rose(wake_request));
  c_clear: cover property (wr_q ##2 irq_request == '0);
endmodule
bind ext_irq_top ext_irq_props #(.N(N)) u_props (.ref_clk, .sys_rst, .pin_select, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .irq_request,
  .wake_request, .irq);

// *** sim/ext_irq_pins.sv ***
// Partner model: external sources driving the interrupt pins
`timescale 1ns/1ps
module ext_irq_pins #(
  parameter int N = 4
) (
  input  wire logic         ref_clk,
  input  wire logic [N-1:0] level_cmd,
  output logic      [N-1:0] irq_pin
);
  // Pins move just after an edge, as a source already synchronised to ref_clk
  always_ff @(posedge ref_clk) begin
    irq_pin <= level_cmd;
  end
endmodule

// *** sim/tb.sv ***
// Testbench: register and pin scenarios for the external interrupt block
`timescale 1ns/1ps
module tb;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0]  level_cmd = 4'hf;
  logic [3:0]  pin_sel = 4'hb;
  logic [3:0]  irq_pin, irq_request;
  logic [31:0] hrdata, rd_v;
  logic [1:0]  hresp;
  logic        hreadyout, wake_request, irq;
  int          miscompares = 0;
  int          compares = 0;
  localparam logic [31:0] FLG = ext_irq_pkg::ADDR_FLAGS;
  // 25 MHz
  always #20 ref_clk = ~ref_clk;
  ext_irq_pins u_pins (.ref_clk, .level_cmd, .irq_pin);
  // Input 2 stays unassigned so its edges must be ignored
  ext_irq_top DUT (.ref_clk, .sys_rst, .irq_pin, .pin_select(pin_sel), .hsel, .haddr,
    .htrans, .hwrite, .hsize(ext_irq_pkg::HSIZE_WORD), .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .irq_request, .wake_request, .irq);
  // ========
  // Access tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Single transfer; the one slave's hreadyout is the bus ready
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= ext_irq_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd_v = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd_v, exp);
  endtask
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ========
  // Scenarios
  initial begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Pins idle high, so nothing is active under the reset polarity
    for (int i = 0; i < 5; i++) rd(FLG + 32'(4 * i), 32'h0);
    // Input 0 level high, 1 rising, 3 falling; only 1 may wake, only 0 interrupts
    bus(1'b1, ext_irq_pkg::ADDR_WAKE_ENABLE, 32'h12);
    bus(1'b1, ext_irq_pkg::ADDR_SENSITIVITY, 32'ha);
    bus(1'b1, ext_irq_pkg::ADDR_POLARITY, 32'h3);
    bus(1'b1, ext_irq_pkg::ADDR_IRQ_MASK, 32'h1);
    bus(1'b1, 32'he01fc154, 32'hffffffff);
    rd(32'he01fc154, 32'h0);
    rd(ext_irq_pkg::ADDR_WAKE_ENABLE, 32'h2);
    rd(ext_irq_pkg::ADDR_SENSITIVITY, 32'ha);
    rd(ext_irq_pkg::ADDR_POLARITY, 32'h3);
    // New polarity made inputs 0 and 1 active; quiet the pins, then clear
    rd(FLG, 32'h3);
    level_cmd <= 4'h8;
    repeat (2) @(posedge ref_clk);
    bus(1'b1, FLG, 32'hf);
    rd(FLG, 32'h0);
    // Held level: a clear is refused until the pin goes quiet
    level_cmd <= 4'h9;
    repeat (4) @(posedge ref_clk);
    rd(FLG, 32'h1);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, FLG, 32'h1);
    rd(FLG, 32'h1);
    level_cmd <= 4'h8;
    repeat (2) @(posedge ref_clk);
    bus(1'b1, FLG, 32'h1);
    rd(FLG, 32'h0);
    // Edges set flags once; wake rises although the interrupt is masked
    level_cmd <= 4'h6;
    repeat (4) @(posedge ref_clk);
    rd(FLG, 32'ha);
    chk({26'h0, irq_request, wake_request, irq}, 32'h2a);
    bus(1'b1, FLG, 32'ha);
    rd(FLG, 32'h0);
    chk({26'h0, irq_request, wake_request, irq}, 32'h0);
    // Input 0 held active while unassigned sets nothing until assigned
    pin_sel   <= 4'ha;
    level_cmd <= 4'h7;
    repeat (4) @(posedge ref_clk);
    rd(FLG, 32'h0);
    pin_sel <= 4'hb;
    repeat (4) @(posedge ref_clk);
    rd(FLG, 32'h1);
    // Reset in mid-run; three edges so no stale flag is seen after release
    level_cmd <= 4'hf;
    sys_rst   <= 1'h1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'h0;
    for (int i = 0; i < 5; i++) rd(FLG + 32'(4 * i), 32'h0);
    complete_run();
  end
  // Watchdog: the sequence needs about 125 cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    miscompares++;
    complete_run();
  end
endmodule
